// >>> hwm_map.svh
// Register map constants of the hardware monitor register bank
`ifndef HWM_MAP_SVH
`define HWM_MAP_SVH

// ----------------------------------------------------------------
// Internal register offsets
// ----------------------------------------------------------------
`define HWM_OFS_DEVNUM    6'h00
`define HWM_OFS_MAKER     6'h01
`define HWM_OFS_PART      6'h02
`define HWM_OFS_FIXCAP    6'h03
`define HWM_OFS_STATUS    6'h04
`define HWM_OFS_CTRL      6'h05
`define HWM_OFS_TCAP      6'h08
`define HWM_OFS_TREAD     6'h09
`define HWM_OFS_TCTRL     6'h0A
`define HWM_OFS_VCAP      6'h10
`define HWM_OFS_VREAD     6'h11
`define HWM_OFS_VCTRL     6'h12
`define HWM_OFS_RATE      6'h20

// ----------------------------------------------------------------
// Reset values and fixed contents
// ----------------------------------------------------------------
`define HWM_RST_CTRL      16'h0000
`define HWM_RST_TCTRL     16'h0000
`define HWM_RST_VCTRL     16'h001F
`define HWM_RST_RATE      2'h2
`define HWM_RST_STATUS    8'h00
`define HWM_VAL_FIXCAP    16'h0021
`define HWM_VAL_TCAP      16'h0349
`define HWM_VAL_VCAP      16'h0051

// ----------------------------------------------------------------
// Bit masks, field positions and device addresses
// ----------------------------------------------------------------
`define HWM_MSK_CTRL      16'h0037
`define HWM_MSK_TCTRL     16'h0007
`define HWM_MSK_VCTRL     16'h07FF
`define HWM_MSK_RATE      16'h0003
`define HWM_MSK_STATUS    8'hB3
`define HWM_BIT_RESET     0
`define HWM_BIT_BER       7
`define HWM_DEV_BCAST     3'h0
`define HWM_DEV_STRAP_LO  3'h1
`define HWM_DEV_STRAP_HI  3'h7

`endif

// >>> hwm_pkg.sv
// Shared types of the hardware monitor register bank
package hwm_pkg;
  typedef logic [5:0]  hwm_addr_t;
  typedef logic [15:0] hwm_data_t;
  typedef logic [2:0]  hwm_dev_t;
endpackage : hwm_pkg

// >>> hwm_regbank.sv
// Register bank of a two-zone temperature, five-channel voltage monitor
`timescale 1ns/1ns
`include "hwm_map.svh"

// Function
// - Power-up reset performs the full device reset before serving accesses.
// - Writing 1 to control bit 0 at 05h triggers the device reset.
// - Device reset abandons operations in progress and restarts the device.
// - Device reset loads every register default, reset bit included.
// - Device number field reads 001 for strap low, 111 high; upper bits zero.
// - Device number field follows the strap input continuously.
// - Writes to the device number register at 00h are ignored.
// - Device number value comes from the strap level, not a constant.
// - Device answers its strap-derived bus address, and broadcast address 0 for writes to 05h.
// - Data fields are 8 or 16 bits by register size, MSB first.
// - Bus error flag clears on device reset and on status register read.
module hwm_regbank #(
  parameter int        DATA_W  = 16,
  parameter bit [15:0] MAKER_ID = 16'h5A5A,  // Arbitrary value
  parameter bit [15:0] PART_ID  = 16'h0A5A   // Arbitrary value
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             STRAP_ADDR,
  input  wire logic             REQ_VALID,
  input  wire hwm_pkg::hwm_dev_t  REQ_DEV,
  input  wire hwm_pkg::hwm_addr_t REQ_ADDR,
  input  wire logic             REQ_WRITE,
  input  wire hwm_pkg::hwm_data_t REQ_WDATA,
  input  wire logic             ACK_ERROR,
  input  wire logic [3:0]       EVT_SET,
  input  wire logic [3:0]       EVT_CLR,
  input  wire hwm_pkg::hwm_data_t TEMP_READOUT,
  input  wire hwm_pkg::hwm_data_t VOLT_READOUT,
  output logic                  READ_VALID,
  output hwm_pkg::hwm_data_t    READ_DATA,
  output logic                  READ_WIDTH16,
  output logic                  DEV_RESET,
  output hwm_pkg::hwm_dev_t     OWN_ADDR,
  output hwm_pkg::hwm_data_t    DEV_CTRL,
  output hwm_pkg::hwm_data_t    TEMP_CTRL,
  output hwm_pkg::hwm_data_t    VOLT_CTRL,
  output logic [1:0]            CONV_RATE
);

  // Only a 16-bit data path is implemented
  if (DATA_W != 16) begin : g_bad_data_w
    $error("hwm_regbank: DATA_W must be 16");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hwm_pkg::hwm_data_t ctrl_r;
  hwm_pkg::hwm_data_t tctrl_r;
  hwm_pkg::hwm_data_t vctrl_r;
  logic [1:0]         rate_r;
  logic [7:0]         status_r;
  logic [7:0]         status_nxt;
  hwm_pkg::hwm_addr_t rd_addr_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire               dev_rst = RST | ctrl_r[`HWM_BIT_RESET];
  wire hwm_pkg::hwm_dev_t strap_dev = STRAP_ADDR ? `HWM_DEV_STRAP_HI
                                                 : `HWM_DEV_STRAP_LO;
  wire               own_hit = (REQ_DEV == strap_dev);
  // Broadcast only reaches the control register, and only as a write
  wire               bc_hit  = (REQ_DEV == `HWM_DEV_BCAST) & REQ_WRITE &
                               (REQ_ADDR == `HWM_OFS_CTRL);
  wire               acc     = REQ_VALID & ~dev_rst & (own_hit | bc_hit);
  wire               wr      = acc & REQ_WRITE;
  wire               rd      = acc & ~REQ_WRITE;
  wire               wr_ctrl  = wr & (REQ_ADDR == `HWM_OFS_CTRL);
  wire               wr_tctrl = wr & (REQ_ADDR == `HWM_OFS_TCTRL);
  wire               wr_vctrl = wr & (REQ_ADDR == `HWM_OFS_VCTRL);
  wire               wr_rate  = wr & (REQ_ADDR == `HWM_OFS_RATE);
  wire               rd_stat  = rd & (REQ_ADDR == `HWM_OFS_STATUS);

  // Read multiplexer; undefined offsets read zero
  logic [15:0] rd_mux;
  logic        rd_w16;
  always_comb begin
    rd_mux = 16'h0000;
    rd_w16 = 1'b1;
    case (REQ_ADDR)
      `HWM_OFS_DEVNUM: begin
        rd_mux = {13'h0, strap_dev};
        rd_w16 = 1'b0;
      end
      `HWM_OFS_MAKER:  rd_mux = MAKER_ID;
      `HWM_OFS_PART:   rd_mux = PART_ID;
      `HWM_OFS_FIXCAP: rd_mux = `HWM_VAL_FIXCAP;
      `HWM_OFS_STATUS: begin
        rd_mux = {8'h00, status_r & `HWM_MSK_STATUS};
        rd_w16 = 1'b0;
      end
      `HWM_OFS_CTRL:   rd_mux = ctrl_r & `HWM_MSK_CTRL;
      `HWM_OFS_TCAP:   rd_mux = `HWM_VAL_TCAP;
      `HWM_OFS_TREAD:  rd_mux = TEMP_READOUT;
      `HWM_OFS_TCTRL:  rd_mux = tctrl_r & `HWM_MSK_TCTRL;
      `HWM_OFS_VCAP:   rd_mux = `HWM_VAL_VCAP;
      `HWM_OFS_VREAD:  rd_mux = VOLT_READOUT;
      `HWM_OFS_VCTRL:  rd_mux = vctrl_r & `HWM_MSK_VCTRL;
      `HWM_OFS_RATE: begin
        rd_mux = {14'h0, rate_r};
        rd_w16 = 1'b0;
      end
      default: begin
        rd_mux = 16'h0000;
        rd_w16 = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Status flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_comb begin
    status_nxt = status_r;
    if (rd_stat) status_nxt[`HWM_BIT_BER] = 1'b0;
    status_nxt[1:0] = (status_r[1:0] & ~EVT_CLR[1:0]) | EVT_SET[1:0];
    status_nxt[5:4] = (status_r[5:4] & ~EVT_CLR[3:2]) | EVT_SET[3:2];
    if (ACK_ERROR) status_nxt[`HWM_BIT_BER] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (dev_rst) begin
      ctrl_r   <= `HWM_RST_CTRL;
      tctrl_r  <= `HWM_RST_TCTRL;
      vctrl_r  <= `HWM_RST_VCTRL;
      rate_r   <= `HWM_RST_RATE;
      status_r <= `HWM_RST_STATUS;
    end else begin
      // Device number has no storage, so writes there fall away
      if (wr_ctrl)  ctrl_r  <= REQ_WDATA & `HWM_MSK_CTRL;
      if (wr_tctrl) tctrl_r <= REQ_WDATA & `HWM_MSK_TCTRL;
      if (wr_vctrl) vctrl_r <= REQ_WDATA & `HWM_MSK_VCTRL;
      if (wr_rate)  rate_r  <= REQ_WDATA[1:0];
      status_r <= status_nxt & `HWM_MSK_STATUS;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      READ_VALID   <= 1'b0;
      READ_DATA    <= 16'h0000;
      READ_WIDTH16 <= 1'b0;
      rd_addr_r    <= 6'h00;
    end else begin
      READ_VALID <= rd;
      if (rd) begin
        READ_DATA    <= rd_mux;
        READ_WIDTH16 <= rd_w16;
        rd_addr_r    <= REQ_ADDR;
      end
    end
  end

  // Restart pulse for the measurement engines; held high through reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      DEV_RESET <= 1'b1;
      // Reset value comes from the strap level, never a fixed code
      OWN_ADDR  <= strap_dev;
    end else begin
      DEV_RESET <= dev_rst;
      OWN_ADDR  <= strap_dev;
    end
  end

  assign DEV_CTRL  = ctrl_r;
  assign TEMP_CTRL = tctrl_r;
  assign VOLT_CTRL = vctrl_r;
  assign CONV_RATE = rate_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Software reset, counted from the edge that takes the write
  sequence s_soft_write;
    wr_ctrl && REQ_WDATA[`HWM_BIT_RESET];
  endsequence

  sequence s_soft_armed;
    ctrl_r[`HWM_BIT_RESET] && !DEV_RESET;
  endsequence

  sequence s_soft_cleared;
    DEV_RESET && ctrl_r == `HWM_RST_CTRL;
  endsequence

  sequence s_soft_reset_done;
    ##1 s_soft_armed ##1 s_soft_cleared;
  endsequence

  // Register read: taken on one edge, answered on the next one only
  sequence s_read_taken;
    rd;
  endsequence

  sequence s_read_answer;
    ##1 READ_VALID;
  endsequence

  AST_PWRUP_QUIET: assert property (
    @(posedge CLK) RST |=> !READ_VALID && DEV_RESET)
    else $error("Read answered during power-up reset");

  AST_PWRUP_DEVNUM: assert property (
    @(posedge CLK) RST |=>
      OWN_ADDR == ($past(STRAP_ADDR) ? `HWM_DEV_STRAP_HI : `HWM_DEV_STRAP_LO))
    else $error("Device number at reset not taken from strap");

  AST_SOFT_RESET: assert property (
    @(posedge CLK) disable iff (RST)
    s_soft_write |-> s_soft_reset_done)
    else $error("Reset bit write did not run device reset");

  AST_BCAST_CTRL: assert property (
    @(posedge CLK) disable iff (RST)
    REQ_VALID && REQ_WRITE && REQ_DEV == `HWM_DEV_BCAST && REQ_ADDR == `HWM_OFS_CTRL &&
      !dev_rst |=> ctrl_r == ($past(REQ_WDATA) & `HWM_MSK_CTRL))
    else $error("Broadcast control write not taken");

  AST_RESTART: assert property (
    @(posedge CLK) disable iff (RST)
    ctrl_r[`HWM_BIT_RESET] |=> DEV_RESET && !ctrl_r[`HWM_BIT_RESET])
    else $error("Restart pulse missing after soft reset");

  // Requests met while the reset bit is set are dropped, not queued
  AST_SOFT_REFUSE: assert property (
    @(posedge CLK) disable iff (RST)
    ctrl_r[`HWM_BIT_RESET] |=> !READ_VALID)
    else $error("Read answered during soft reset");

  AST_DEFAULTS: assert property (
    @(posedge CLK) dev_rst |=>
      ctrl_r == `HWM_RST_CTRL && tctrl_r == `HWM_RST_TCTRL && vctrl_r == `HWM_RST_VCTRL &&
      rate_r == `HWM_RST_RATE && status_r == `HWM_RST_STATUS)
    else $error("Register not at default after reset");

  AST_STRAP_FIELD: assert property (
    @(posedge CLK) disable iff (RST)
    READ_VALID && rd_addr_r == `HWM_OFS_DEVNUM |->
      READ_DATA == {13'h0, ($past(STRAP_ADDR) ? `HWM_DEV_STRAP_HI : `HWM_DEV_STRAP_LO)})
    else $error("Device number field wrong for strap");

  // No reset gating: the field follows the pin in reset as well
  AST_STRAP_TRACK: assert property (
    @(posedge CLK) $changed(STRAP_ADDR) |=>
      OWN_ADDR == ($past(STRAP_ADDR) ? `HWM_DEV_STRAP_HI : `HWM_DEV_STRAP_LO))
    else $error("Own address did not follow strap");

  AST_DEVNUM_RO: assert property (
    @(posedge CLK) disable iff (dev_rst)
    wr && REQ_ADDR == `HWM_OFS_DEVNUM |=>
      $stable(ctrl_r) && $stable(tctrl_r) && $stable(vctrl_r) && $stable(rate_r))
    else $error("Write to device number changed state");

  AST_SELECT: assert property (
    @(posedge CLK) disable iff (RST)
    REQ_VALID && !REQ_WRITE && REQ_DEV != strap_dev |=> !READ_VALID)
    else $error("Read answered for foreign address");

  AST_BCAST_READ: assert property (
    @(posedge CLK) disable iff (RST)
    REQ_VALID && !REQ_WRITE && REQ_DEV == `HWM_DEV_BCAST |=> !READ_VALID)
    else $error("Broadcast read was answered");

  AST_READ_TIMING: assert property (
    @(posedge CLK) disable iff (RST)
    s_read_taken |-> s_read_answer)
    else $error("Read answer not one cycle after request");

  AST_READ_UNASKED: assert property (
    @(posedge CLK) disable iff (RST)
    !rd |=> !READ_VALID)
    else $error("Read answer without a taken request");

  AST_WIDTH8: assert property (
    @(posedge CLK) disable iff (RST)
    READ_VALID && rd_addr_r inside {`HWM_OFS_DEVNUM, `HWM_OFS_STATUS, `HWM_OFS_RATE} |->
      !READ_WIDTH16 && READ_DATA[15:8] == 8'h00)
    else $error("Eight-bit register returned wide field");

  AST_WIDTH16: assert property (
    @(posedge CLK) disable iff (RST)
    READ_VALID && rd_addr_r inside {`HWM_OFS_MAKER, `HWM_OFS_CTRL, `HWM_OFS_VCTRL} |->
      READ_WIDTH16)
    else $error("Sixteen-bit register returned narrow field");

  AST_BER_CLEAR: assert property (
    @(posedge CLK) disable iff (RST)
    rd_stat && !ACK_ERROR |=> !status_r[`HWM_BIT_BER])
    else $error("Bus error flag survived status read");

  AST_BER_SET: assert property (
    @(posedge CLK) disable iff (RST)
    ACK_ERROR && !dev_rst |=> status_r[`HWM_BIT_BER])
    else $error("Bus error flag not set");

  // A fresh error must not be lost to a read in the same cycle
  AST_BER_SET_WINS: assert property (
    @(posedge CLK) disable iff (RST)
    rd_stat && ACK_ERROR |=> status_r[`HWM_BIT_BER])
    else $error("Bus error flag lost to simultaneous read");

  AST_RESERVED: assert property (
    @(posedge CLK) disable iff (RST)
    READ_VALID && rd_addr_r == `HWM_OFS_CTRL |-> (READ_DATA & ~`HWM_MSK_CTRL) == 16'h0000)
    else $error("Reserved control bit read nonzero");

  AST_STATUS_RESERVED: assert property (
    @(posedge CLK) disable iff (RST)
    READ_VALID && rd_addr_r == `HWM_OFS_STATUS |->
      (READ_DATA & ~{8'h00, `HWM_MSK_STATUS}) == 16'h0000)
    else $error("Reserved status bit read nonzero");

  AST_RATE_RESERVED: assert property (
    @(posedge CLK) disable iff (RST)
    READ_VALID && rd_addr_r == `HWM_OFS_RATE |-> READ_DATA[15:2] == 14'h0)
    else $error("Reserved rate bit read nonzero");

endmodule : hwm_regbank

// >>> hwm_master_model.sv
// Behavioural transaction engine standing in for the bus master
`timescale 1ns/1ns

module hwm_master_model (
  input  wire logic         CLK,
  output logic              REQ_VALID,
  output hwm_pkg::hwm_dev_t  REQ_DEV,
  output hwm_pkg::hwm_addr_t REQ_ADDR,
  output logic              REQ_WRITE,
  output hwm_pkg::hwm_data_t REQ_WDATA
);
  initial begin
    REQ_VALID = 1'b0;
    REQ_DEV   = 3'h6;
    REQ_ADDR  = 6'h3F;
    REQ_WRITE = 1'b0;
    REQ_WDATA = 16'hFFFF;
  end

  // ----------------------------------------------------------------
  // One completed transaction, optionally after some idle cycles
  // ----------------------------------------------------------------
  task automatic xfer(input hwm_pkg::hwm_dev_t d, input hwm_pkg::hwm_addr_t a,
                      input logic w, input hwm_pkg::hwm_data_t v, input int gap);
    repeat (gap) @(negedge CLK);
    @(negedge CLK);
    REQ_DEV   = d;
    REQ_ADDR  = a;
    REQ_WRITE = w;
    REQ_WDATA = v;
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    // Released lines show the inverse so stale values never pass
    REQ_DEV   = ~d;
    REQ_ADDR  = ~a;
    REQ_WRITE = ~w;
    REQ_WDATA = ~v;
  endtask : xfer
endmodule : hwm_master_model

// >>> tb_hw_monitor_register_map.sv
// Self-checking testbench of the hardware monitor register bank
`timescale 1ns/1ns

module tb_hw_monitor_register_map;
  localparam bit [15:0] MAKER = 16'h3C3C; // Arbitrary value
  localparam bit [15:0] PART  = 16'h0C3C; // Arbitrary value
  logic               CLK, RST, STRAP_ADDR, REQ_VALID, REQ_WRITE, ACK_ERROR;
  logic               READ_VALID, READ_WIDTH16, DEV_RESET;
  logic [3:0]         EVT_SET, EVT_CLR;
  logic [1:0]         CONV_RATE;
  hwm_pkg::hwm_dev_t  REQ_DEV, OWN_ADDR;
  hwm_pkg::hwm_addr_t REQ_ADDR;
  hwm_pkg::hwm_data_t REQ_WDATA, TEMP_READOUT, VOLT_READOUT, READ_DATA;
  hwm_pkg::hwm_data_t DEV_CTRL, TEMP_CTRL, VOLT_CTRL;
  hwm_pkg::hwm_data_t m_ctrl = 16'h0, m_t = 16'h0, m_v = 16'h1F, m_rate = 16'h2;
  logic [7:0]         m_stat = 8'h0;
  logic [31:0]        seed = 32'h86C0;
  int                 n_fail = 0, check_count = 0;
  hwm_pkg::hwm_addr_t al[9] = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h08, 6'h0A, 6'h12, 6'h20, 6'h30};

  hwm_regbank #(.MAKER_ID(MAKER), .PART_ID(PART)) hwm_regbank_inst (
    .CLK(CLK), .RST(RST), .STRAP_ADDR(STRAP_ADDR), .REQ_VALID(REQ_VALID),
    .REQ_DEV(REQ_DEV), .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE), .REQ_WDATA(REQ_WDATA),
    .ACK_ERROR(ACK_ERROR), .EVT_SET(EVT_SET), .EVT_CLR(EVT_CLR),
    .TEMP_READOUT(TEMP_READOUT), .VOLT_READOUT(VOLT_READOUT), .READ_VALID(READ_VALID),
    .READ_DATA(READ_DATA), .READ_WIDTH16(READ_WIDTH16), .DEV_RESET(DEV_RESET),
    .OWN_ADDR(OWN_ADDR), .DEV_CTRL(DEV_CTRL), .TEMP_CTRL(TEMP_CTRL),
    .VOLT_CTRL(VOLT_CTRL), .CONV_RATE(CONV_RATE));

  hwm_master_model hwm_master_model_inst (
    .CLK(CLK), .REQ_VALID(REQ_VALID), .REQ_DEV(REQ_DEV), .REQ_ADDR(REQ_ADDR),
    .REQ_WRITE(REQ_WRITE), .REQ_WDATA(REQ_WDATA));

  // ----------------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Width flag in bit 16, field value below
  function automatic logic [16:0] expv(input hwm_pkg::hwm_addr_t a);
    case (a)
      6'h00: return {14'h0, STRAP_ADDR ? 3'h7 : 3'h1};
      6'h01: return {1'b1, MAKER};
      6'h02: return {1'b1, PART};
      6'h03: return 17'h10021;
      6'h04: return {9'h0, m_stat};
      6'h05: return {1'b1, m_ctrl};
      6'h08: return 17'h10349;
      6'h09: return {1'b1, TEMP_READOUT};
      6'h0A: return {1'b1, m_t};
      6'h10: return 17'h10051;
      6'h11: return {1'b1, VOLT_READOUT};
      6'h12: return {1'b1, m_v};
      6'h20: return {1'b0, m_rate};
      default: return 17'h10000;
    endcase
  endfunction : expv

  task automatic cmp(input logic [16:0] act, input logic [16:0] exp);
    check_count++;
    if (act !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, act, exp);
    end
  endtask : cmp

  task automatic rd(input hwm_pkg::hwm_dev_t d, input hwm_pkg::hwm_addr_t a, input bit ans);
    logic [16:0] e;
    e = expv(a);
    hwm_master_model_inst.xfer(d, a, 1'b0, 16'h0, 0);
    cmp({16'h0, READ_VALID}, {16'h0, ans});
    if (ans) cmp({READ_WIDTH16, READ_DATA}, e);
    if (ans && a == 6'h04) m_stat[7] = 1'b0;
  endtask : rd

  task automatic wr(input hwm_pkg::hwm_dev_t d, input hwm_pkg::hwm_addr_t a,
                    input hwm_pkg::hwm_data_t v, input int gap);
    hwm_master_model_inst.xfer(d, a, 1'b1, v, gap);
    if (d == (STRAP_ADDR ? 3'h7 : 3'h1) || (d == 3'h0 && a == 6'h05))
      case (a)
        6'h05: m_ctrl = v & 16'h0037;
        6'h0A: m_t = v & 16'h0007;
        6'h12: m_v = v & 16'h07FF;
        6'h20: m_rate = v & 16'h0003;
        default: ;
      endcase
    cmp_ctl();
    if (m_ctrl[0]) begin
      @(negedge CLK);
      cmp({16'h0, DEV_RESET}, 17'h1);
      m_ctrl = 16'h0;
      m_t = 16'h0;
      m_v = 16'h1F;
      m_rate = 16'h2;
      m_stat = 8'h0;
      @(negedge CLK);
      cmp({16'h0, DEV_RESET}, 17'h0);
      cmp_ctl();
    end
  endtask : wr

  task automatic cmp_ctl();
    cmp({1'b0, DEV_CTRL}, {1'b0, m_ctrl});
    cmp({1'b0, TEMP_CTRL}, {1'b0, m_t});
    cmp({1'b0, VOLT_CTRL}, {1'b0, m_v});
    cmp({15'h0, CONV_RATE}, {1'b0, m_rate});
  endtask : cmp_ctl

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  initial begin
    repeat (5000) @(posedge CLK);
    n_fail++;
    close_out();
  end

  initial begin
    RST = 1'b1;
    {STRAP_ADDR, ACK_ERROR, EVT_SET, EVT_CLR} = 10'h0;
    TEMP_READOUT = 16'(xs());
    VOLT_READOUT = 16'(xs());
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    cmp({16'h0, DEV_RESET}, 17'h1);
    cmp_ctl();
    RST = 1'b0;
    for (int a = 0; a < 64; a++) rd(3'h1, 6'(a), 1'b1);
    cmp({16'h0, DEV_RESET}, 17'h0);
    for (int i = 0; i < 8; i++)
      foreach (al[j]) begin
        wr(3'h1, al[j], 16'(xs()) & 16'hFFFE, i % 3);
        rd(3'h1, al[j], 1'b1);
      end
    STRAP_ADDR = 1'b1;
    rd(3'h7, 6'h00, 1'b1);
    cmp({14'h0, OWN_ADDR}, 17'h7);
    rd(3'h1, 6'h00, 1'b0);
    wr(3'h7, 6'h20, 16'h0001, 1);
    rd(3'h7, 6'h20, 1'b1);
    STRAP_ADDR = 1'b0;
    rd(3'h0, 6'h05, 1'b0);
    {ACK_ERROR, EVT_SET} = 5'h1F;
    @(negedge CLK) {ACK_ERROR, EVT_SET} = 5'h0;
    m_stat = 8'hB3;
    rd(3'h1, 6'h04, 1'b1);
    rd(3'h1, 6'h04, 1'b1);
    EVT_CLR = 4'hF;
    @(negedge CLK) EVT_CLR = 4'h0;
    m_stat = 8'h00;
    rd(3'h1, 6'h04, 1'b1);
    {ACK_ERROR, EVT_SET} = 5'h11;
    @(negedge CLK) {ACK_ERROR, EVT_SET} = 5'h0;
    m_stat = 8'h81;
    // Error and flag set land on the edge that takes a status read: sets win
    fork
      rd(3'h1, 6'h04, 1'b1);
      begin
        @(negedge CLK) {ACK_ERROR, EVT_SET, EVT_CLR} = 9'h111;
        @(negedge CLK) {ACK_ERROR, EVT_SET, EVT_CLR} = 9'h000;
      end
    join
    m_stat = 8'h81;
    rd(3'h1, 6'h04, 1'b1);
    wr(3'h1, 6'h12, 16'h0555, 0);
    wr(3'h1, 6'h0A, 16'h0007, 0);
    wr(3'h0, 6'h05, 16'h0031, 1);
    foreach (al[j]) rd(3'h1, al[j], 1'b1);
    close_out();
  end
endmodule : tb_hw_monitor_register_map
